// file: src/thermal_stage.sv
// thermal overload output stage with apb register slave
// Summary of operation
// - ambient curve uses two to ten pairs; extra pairs ignored unless marked used
// - below lowest curve point use first coefficient, above highest use last
// - alarm1, alarm2, inhibit, trip from capacity versus thresholds; 80 and 100 percent
// - thresholds in 0.1 percent steps; both alarm thresholds default 40 percent
// - alarm1, alarm2, inhibit and trip each have their own enable, start and blocked follow the trip enable; disabled by default; disabled drops at next cycle
// - trip postponed by extra delay up to 3600 s in 5 ms steps
// - blocking sampled once at start of each program cycle, used throughout it
// - pick-up while unblocked raises start and runs the operate delay
// - pick-up while blocked raises blocked and goes no further
// - blocking after start clears start and releases as on drop-out
// - six-value condition code; normal means no alarm, inhibit, trip or blocked output is driven, start may be on
// - load class light, normal, overloading, high overload from current
// - invalid service factor replaced by 1.0 with a fault flag while invalid
// - invalid ambient settings give correction 1.0 and ambient fault flag
// - bad nominal current setting replaced by 1.0 with its fault flag
// - inconsistent ambient factors raise a separate flag while they persist
// - settings change while running, no restart needed
// - linear mode above maximum ambient uses the maximum-temperature factor
// - linear mode below minimum ambient uses the minimum-temperature factor
`timescale 1ns/10ps
`default_nettype none
module thermal_stage #(
  parameter int unsigned PROG_CYCLE_CLKS = thermal_stage_pkg::PROG_CYCLE_CLKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] capacity,
  input wire logic [15:0] current_meas,
  input wire logic signed [12:0] ambient_temp,
  input wire logic block_in,
  output thermal_stage_pkg::stage_out_t stage_out,
  output thermal_stage_pkg::cond_t operating_condition_code,
  output thermal_stage_pkg::load_class_t load_class,
  output thermal_stage_pkg::fault_flags_t setting_fault_flag,
  output logic [8:0] ambient_k_used,
  output logic [8:0] service_factor_used,
  output logic [8:0] nominal_used,
  output logic cycle_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic signed [12:0] pt_temp(input logic [31:0] pt);
    pt_temp = $signed(pt[thermal_stage_pkg::PT_TEMP_MSB:0]);
  endfunction

  function automatic logic [8:0] pt_k(input logic [31:0] pt);
    pt_k = pt[thermal_stage_pkg::PT_K_MSB:thermal_stage_pkg::PT_K_LSB];
  endfunction

  function automatic logic factor_ok(input logic [8:0] k);
    factor_ok = (k != 9'h000) && (k <= thermal_stage_pkg::FACTOR_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] ctrl_reg, ctrl_next;
  logic [10:0] lvl_reg [4], lvl_next [4];
  logic [19:0] trip_delay_reg, trip_delay_next;
  logic [8:0] sf_reg, sf_next;
  logic [8:0] nominal_reg, nominal_next;
  logic [31:0] amb_min_reg, amb_min_next;
  logic [31:0] amb_max_reg, amb_max_next;
  logic [15:0] pickup_reg, pickup_next;
  logic [31:0] curve_reg [thermal_stage_pkg::CURVE_POINTS];
  logic [31:0] curve_next [thermal_stage_pkg::CURVE_POINTS];
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic wr_en;
  logic hit;
  logic [31:0] rd_mux;
  logic [7:0] idx;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // level, delay and pick-up settings take effect on the next program cycle, factor checks on the next clock; the stage keeps running
  always_comb
  begin
    ctrl_next = ctrl_reg;
    for (int i = 0; i < 4; i++)
      lvl_next[i] = lvl_reg[i];
    trip_delay_next = trip_delay_reg;
    sf_next = sf_reg;
    nominal_next = nominal_reg;
    amb_min_next = amb_min_reg;
    amb_max_next = amb_max_reg;
    pickup_next = pickup_reg;
    for (int i = 0; i < thermal_stage_pkg::CURVE_POINTS; i++)
      curve_next[i] = curve_reg[i];
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    idx = paddr - thermal_stage_pkg::CURVE_BASE_OFS;
    case (paddr)
      thermal_stage_pkg::CTRL_OFS: rd_mux = {27'h0, ctrl_reg};
      thermal_stage_pkg::ALARM1_LEVEL_OFS: rd_mux = {21'h0, lvl_reg[0]};
      thermal_stage_pkg::ALARM2_LEVEL_OFS: rd_mux = {21'h0, lvl_reg[1]};
      thermal_stage_pkg::INHIBIT_LEVEL_OFS: rd_mux = {21'h0, lvl_reg[2]};
      thermal_stage_pkg::TRIP_LEVEL_OFS: rd_mux = {21'h0, lvl_reg[3]};
      thermal_stage_pkg::TRIP_DELAY_OFS: rd_mux = {12'h0, trip_delay_reg};
      thermal_stage_pkg::SERVICE_FACTOR_OFS: rd_mux = {23'h0, sf_reg};
      thermal_stage_pkg::NOMINAL_OFS: rd_mux = {23'h0, nominal_reg};
      thermal_stage_pkg::AMB_MIN_OFS: rd_mux = amb_min_reg;
      thermal_stage_pkg::AMB_MAX_OFS: rd_mux = amb_max_reg;
      thermal_stage_pkg::PICKUP_CURR_OFS: rd_mux = {16'h0, pickup_reg};
      thermal_stage_pkg::STATUS_OFS:
        rd_mux = {17'h0, setting_fault_flag, load_class, operating_condition_code,
          stage_out};
      thermal_stage_pkg::USED_OFS:
        rd_mux = {5'h0, nominal_used, service_factor_used, ambient_k_used};
      default:
      begin
        hit = (paddr >= thermal_stage_pkg::CURVE_BASE_OFS) && (paddr[1:0] == 2'b00)
          && (idx[7:2] < 6'(thermal_stage_pkg::CURVE_POINTS));
        rd_mux = hit ? curve_reg[idx[5:2]] : 32'h0000_0000;
      end
    endcase
    if (wr_en && hit)
    begin
      case (paddr)
        thermal_stage_pkg::CTRL_OFS: ctrl_next = pwdata[4:0];
        thermal_stage_pkg::ALARM1_LEVEL_OFS: lvl_next[0] = pwdata[10:0];
        thermal_stage_pkg::ALARM2_LEVEL_OFS: lvl_next[1] = pwdata[10:0];
        thermal_stage_pkg::INHIBIT_LEVEL_OFS: lvl_next[2] = pwdata[10:0];
        thermal_stage_pkg::TRIP_LEVEL_OFS: lvl_next[3] = pwdata[10:0];
        thermal_stage_pkg::TRIP_DELAY_OFS:
          trip_delay_next = (pwdata[19:0] > thermal_stage_pkg::TRIP_DELAY_MAX_STEPS
            || pwdata[31:20] != 12'h000) ? thermal_stage_pkg::TRIP_DELAY_MAX_STEPS
            : pwdata[19:0];
        thermal_stage_pkg::SERVICE_FACTOR_OFS: sf_next = pwdata[8:0];
        thermal_stage_pkg::NOMINAL_OFS: nominal_next = pwdata[8:0];
        thermal_stage_pkg::AMB_MIN_OFS: amb_min_next = pwdata;
        thermal_stage_pkg::AMB_MAX_OFS: amb_max_next = pwdata;
        thermal_stage_pkg::PICKUP_CURR_OFS: pickup_next = pwdata[15:0];
        thermal_stage_pkg::STATUS_OFS: ;
        thermal_stage_pkg::USED_OFS: ;
        default: curve_next[idx[5:2]] = pwdata;
      endcase
    end
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    // answer is prepared in the setup cycle so it leaves a flip-flop
    if (psel && !penable)
    begin
      prdata_next = pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_next = !hit;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= 5'h00;
      lvl_reg[0] <= thermal_stage_pkg::ALARM_LEVEL_RST;
      lvl_reg[1] <= thermal_stage_pkg::ALARM_LEVEL_RST;
      lvl_reg[2] <= thermal_stage_pkg::INHIBIT_LEVEL_RST;
      lvl_reg[3] <= thermal_stage_pkg::TRIP_LEVEL_RST;
      trip_delay_reg <= 20'h00000;
      sf_reg <= thermal_stage_pkg::FACTOR_ONE;
      nominal_reg <= thermal_stage_pkg::FACTOR_ONE;
      amb_min_reg <= thermal_stage_pkg::AMB_MIN_RST;
      amb_max_reg <= thermal_stage_pkg::AMB_MAX_RST;
      pickup_reg <= thermal_stage_pkg::PICKUP_CURR_RST;
      for (int i = 0; i < thermal_stage_pkg::CURVE_POINTS; i++)
        curve_reg[i] <= thermal_stage_pkg::CURVE_PT_RST;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      lvl_reg <= lvl_next;
      trip_delay_reg <= trip_delay_next;
      sf_reg <= sf_next;
      nominal_reg <= nominal_next;
      amb_min_reg <= amb_min_next;
      amb_max_reg <= amb_max_next;
      pickup_reg <= pickup_next;
      curve_reg <= curve_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // setting checks and ambient correction
  logic [8:0] amb_k;
  logic amb_order_bad, amb_k_bad;
  logic signed [12:0] last_temp;
  logic pt_used;

  always_comb
  begin
    amb_k = thermal_stage_pkg::FACTOR_ONE;
    amb_order_bad = 1'b0;
    amb_k_bad = 1'b0;
    last_temp = 13'sh0000;
    pt_used = 1'b0;
    if (ctrl_reg[thermal_stage_pkg::CTRL_CURVE_BIT])
    begin
      amb_k = pt_k(curve_reg[0]);
      last_temp = pt_temp(curve_reg[0]);
      for (int i = 0; i < thermal_stage_pkg::CURVE_POINTS; i++)
      begin
        // the first two pairs are always in the curve
        pt_used = (i < thermal_stage_pkg::CURVE_MIN_POINTS)
          || curve_reg[i][thermal_stage_pkg::PT_USED_BIT];
        if (pt_used)
        begin
          if (!factor_ok(pt_k(curve_reg[i])))
            amb_k_bad = 1'b1;
          if (i > 0 && pt_temp(curve_reg[i]) <= last_temp)
            amb_order_bad = 1'b1;
          // step to the highest used point at or below the reading
          if (ambient_temp >= pt_temp(curve_reg[i]))
            amb_k = pt_k(curve_reg[i]);
          last_temp = pt_temp(curve_reg[i]);
        end
      end
    end
    else
    begin
      amb_k_bad = !factor_ok(pt_k(amb_min_reg)) || !factor_ok(pt_k(amb_max_reg));
      amb_order_bad = pt_temp(amb_min_reg) >= pt_temp(amb_max_reg);
      if (ambient_temp > pt_temp(amb_max_reg))
        amb_k = pt_k(amb_max_reg);
      else if (ambient_temp < pt_temp(amb_min_reg))
        amb_k = pt_k(amb_min_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // program cycle and pick-up sequencing
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic block_reg, block_next;
  thermal_stage_pkg::stage_state_t state_reg, state_next;
  logic [19:0] delay_cnt_reg, delay_cnt_next;
  thermal_stage_pkg::stage_out_t out_reg, out_next;
  thermal_stage_pkg::cond_t cond_reg, cond_next;
  thermal_stage_pkg::load_class_t load_reg, load_next;
  thermal_stage_pkg::fault_flags_t flags_reg, flags_next;
  logic [8:0] k_reg, k_next, sfu_reg, sfu_next, nom_reg, nom_next;
  logic [3:0] en;
  logic pickup;

  assign tick = tick_cnt_reg == 16'(PROG_CYCLE_CLKS - 1);
  assign en = ctrl_reg[thermal_stage_pkg::CTRL_EN_LSB +: 4];
  assign pickup = capacity >= lvl_reg[3];

  always_comb
  begin
    tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    // blocking is latched on the cycle boundary so one cycle sees one value
    block_next = tick ? block_in : block_reg;
    state_next = state_reg;
    delay_cnt_next = delay_cnt_reg;
    out_next = out_reg;
    cond_next = cond_reg;
    load_next = load_reg;
    flags_next.sf_fault = !factor_ok(sf_reg);
    flags_next.nominal_fault = !factor_ok(nominal_reg);
    flags_next.ambient_fault = amb_order_bad;
    flags_next.ambient_k_fault = amb_k_bad;
    sfu_next = flags_next.sf_fault ? thermal_stage_pkg::FACTOR_ONE : sf_reg;
    nom_next = flags_next.nominal_fault ? thermal_stage_pkg::FACTOR_ONE
      : nominal_reg;
    k_next = (amb_order_bad || amb_k_bad) ? thermal_stage_pkg::FACTOR_ONE
      : amb_k;
    if (tick)
    begin
      case (state_reg)
        thermal_stage_pkg::ST_IDLE:
          if (pickup && en[3])
            state_next = block_in ? thermal_stage_pkg::ST_BLOCKED
              : thermal_stage_pkg::ST_START;
        thermal_stage_pkg::ST_START:
          if (!pickup || block_in || !en[3])
            state_next = thermal_stage_pkg::ST_IDLE;
          else if (delay_cnt_reg >= trip_delay_reg)
            state_next = thermal_stage_pkg::ST_TRIPPED;
        thermal_stage_pkg::ST_TRIPPED:
          // clearing the trip enable drops a standing trip at the next cycle
          if (!pickup || block_in || !en[3])
            state_next = thermal_stage_pkg::ST_IDLE;
        thermal_stage_pkg::ST_BLOCKED:
          // a blocked pick-up is not pursued until it drops out
          if (!pickup || !en[3])
            state_next = thermal_stage_pkg::ST_IDLE;
        default: state_next = thermal_stage_pkg::ST_IDLE;
      endcase
      // counter restarts on drop-out or release, as a fresh pick-up would
      if (state_next == thermal_stage_pkg::ST_START && state_reg == thermal_stage_pkg::ST_START)
        delay_cnt_next = delay_cnt_reg + 20'h00001;
      else
        delay_cnt_next = 20'h00000;
      out_next.alarm1 = en[0] && !block_in && capacity >= lvl_reg[0];
      out_next.alarm2 = en[1] && !block_in && capacity >= lvl_reg[1];
      out_next.inhibit = en[2] && !block_in && capacity >= lvl_reg[2];
      out_next.trip = state_next == thermal_stage_pkg::ST_TRIPPED;
      out_next.start = state_next == thermal_stage_pkg::ST_START
        || state_next == thermal_stage_pkg::ST_TRIPPED;
      out_next.blocked = state_next == thermal_stage_pkg::ST_BLOCKED;
      // highest-severity active output names the condition
      if (out_next.blocked)
        cond_next = thermal_stage_pkg::COND_BLOCKED;
      else if (out_next.trip)
        cond_next = thermal_stage_pkg::COND_TRIP;
      else if (out_next.inhibit)
        cond_next = thermal_stage_pkg::COND_INHIBIT;
      else if (out_next.alarm2)
        cond_next = thermal_stage_pkg::COND_ALARM2;
      else if (out_next.alarm1)
        cond_next = thermal_stage_pkg::COND_ALARM1;
      else
        cond_next = thermal_stage_pkg::COND_NORMAL;
      if (current_meas < thermal_stage_pkg::LIGHT_LOAD_LIMIT)
        load_next = thermal_stage_pkg::LOAD_LIGHT;
      else if (current_meas > thermal_stage_pkg::HIGH_OVERLOAD_LIMIT)
        load_next = thermal_stage_pkg::LOAD_HIGH;
      else if (current_meas > pickup_reg)
        load_next = thermal_stage_pkg::LOAD_OVERLOADING;
      else
        load_next = thermal_stage_pkg::LOAD_NORMAL;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 16'h0000;
      block_reg <= 1'b0;
      state_reg <= thermal_stage_pkg::ST_IDLE;
      delay_cnt_reg <= 20'h00000;
      out_reg <= '0;
      cond_reg <= thermal_stage_pkg::COND_NORMAL;
      load_reg <= thermal_stage_pkg::LOAD_LIGHT;
      flags_reg <= '0;
      k_reg <= thermal_stage_pkg::FACTOR_ONE;
      sfu_reg <= thermal_stage_pkg::FACTOR_ONE;
      nom_reg <= thermal_stage_pkg::FACTOR_ONE;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      block_reg <= block_next;
      state_reg <= state_next;
      delay_cnt_reg <= delay_cnt_next;
      out_reg <= out_next;
      cond_reg <= cond_next;
      load_reg <= load_next;
      flags_reg <= flags_next;
      k_reg <= k_next;
      sfu_reg <= sfu_next;
      nom_reg <= nom_next;
    end
  end

  assign stage_out = out_reg;
  assign operating_condition_code = cond_reg;
  assign load_class = load_reg;
  assign setting_fault_flag = flags_reg;
  assign ambient_k_used = k_reg;
  assign service_factor_used = sfu_reg;
  assign nominal_used = nom_reg;
  assign cycle_tick = tick;

endmodule // thermal_stage
`default_nettype wire

// file: src/thermal_stage_pkg.sv
// constants, register map and carrier types of the thermal overload output stage
package thermal_stage_pkg;
  // program cycle timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_CYCLE_MS = 5;
  localparam int unsigned PROG_CYCLE_CLKS = (PROG_CYCLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned TRIP_DELAY_MAX_S = 3600;
  localparam logic [19:0] TRIP_DELAY_MAX_STEPS = 20'((TRIP_DELAY_MAX_S * 1000) / PROG_CYCLE_MS);
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ALARM1_LEVEL_OFS = 8'h04;
  localparam logic [7:0] ALARM2_LEVEL_OFS = 8'h08;
  localparam logic [7:0] INHIBIT_LEVEL_OFS = 8'h0C;
  localparam logic [7:0] TRIP_LEVEL_OFS = 8'h10;
  localparam logic [7:0] TRIP_DELAY_OFS = 8'h14;
  localparam logic [7:0] SERVICE_FACTOR_OFS = 8'h18;
  localparam logic [7:0] NOMINAL_OFS = 8'h1C;
  localparam logic [7:0] AMB_MIN_OFS = 8'h20;
  localparam logic [7:0] AMB_MAX_OFS = 8'h24;
  localparam logic [7:0] PICKUP_CURR_OFS = 8'h28;
  localparam logic [7:0] STATUS_OFS = 8'h2C;
  localparam logic [7:0] USED_OFS = 8'h30;
  localparam logic [7:0] CURVE_BASE_OFS = 8'h40;
  localparam int unsigned CURVE_POINTS = 10;
  localparam int unsigned CURVE_MIN_POINTS = 2;
  // field positions
  localparam int unsigned CTRL_EN_LSB = 0;
  localparam int unsigned CTRL_CURVE_BIT = 4;
  localparam int unsigned PT_TEMP_MSB = 12;
  localparam int unsigned PT_K_LSB = 16;
  localparam int unsigned PT_K_MSB = 24;
  localparam int unsigned PT_USED_BIT = 31;
  // reset values, thresholds in 0.1 %, factors in 0.01, temperatures in 0.1 deg
  localparam logic [10:0] ALARM_LEVEL_RST = 11'h190;
  localparam logic [10:0] INHIBIT_LEVEL_RST = 11'h320;
  localparam logic [10:0] TRIP_LEVEL_RST = 11'h3E8;
  localparam logic [8:0] FACTOR_ONE = 9'h064;
  localparam logic [8:0] FACTOR_MAX = 9'h1F4;
  localparam logic [31:0] AMB_MIN_RST = 32'h0064_0000;
  localparam logic [31:0] AMB_MAX_RST = 32'h0064_01C2;
  localparam logic [31:0] CURVE_PT_RST = 32'h0001_0096;
  localparam logic [15:0] PICKUP_CURR_RST = 16'h0064;
  // load class limits in 0.01 x nominal
  localparam logic [15:0] LIGHT_LOAD_LIMIT = 16'h0001;
  localparam logic [15:0] HIGH_OVERLOAD_LIMIT = 16'h00C8;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0,
    COND_ALARM1 = 3'h1,
    COND_ALARM2 = 3'h2,
    COND_INHIBIT = 3'h3,
    COND_TRIP = 3'h4,
    COND_BLOCKED = 3'h5
  } cond_t;

  typedef enum logic [1:0] {
    LOAD_LIGHT = 2'h0,
    LOAD_NORMAL = 2'h1,
    LOAD_OVERLOADING = 2'h2,
    LOAD_HIGH = 2'h3
  } load_class_t;

  // gray-coded pick-up states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_TRIPPED = 2'b11,
    ST_BLOCKED = 2'b10
  } stage_state_t;

  typedef struct packed {
    logic alarm1;
    logic alarm2;
    logic inhibit;
    logic trip;
    logic start;
    logic blocked;
  } stage_out_t;

  typedef struct packed {
    logic sf_fault;
    logic ambient_fault;
    logic nominal_fault;
    logic ambient_k_fault;
  } fault_flags_t;
endpackage

// file: testbench/thermal_stage_properties.sv
// assertion checker for the thermal overload output stage
`timescale 1ns/10ps
`default_nettype none
module thermal_stage_checker #(
  parameter int unsigned PROG_CYCLE_CLKS = thermal_stage_pkg::PROG_CYCLE_CLKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] current_meas,
  input wire logic block_in,
  input wire thermal_stage_pkg::stage_out_t stage_out,
  input wire thermal_stage_pkg::cond_t operating_condition_code,
  input wire thermal_stage_pkg::load_class_t load_class,
  input wire thermal_stage_pkg::fault_flags_t setting_fault_flag,
  input wire logic [8:0] ambient_k_used,
  input wire logic [8:0] service_factor_used,
  input wire logic [8:0] nominal_used,
  input wire logic cycle_tick
);
  logic [31:0] gap_reg;
  logic [31:0] gap_next;
  always_comb gap_next = cycle_tick ? 32'h0 : gap_reg + 32'h1;
  always_ff @(posedge clock or posedge rst)
    if (rst) gap_reg <= 32'h0;
    else gap_reg <= gap_next;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  tick_spacing_a: assert property (cycle_tick |-> gap_reg == PROG_CYCLE_CLKS - 1)
    else $error("evaluation tick spacing wrong");
  outputs_hold_a: assert property (!cycle_tick |=> $stable(stage_out)
    && $stable(load_class))
    else $error("outputs moved between ticks");
  normal_quiet_a: assert property (
    operating_condition_code == thermal_stage_pkg::COND_NORMAL
    |-> !(stage_out.alarm1 | stage_out.alarm2 | stage_out.inhibit | stage_out.trip))
    else $error("output driven in normal condition");
  block_clears_a: assert property (cycle_tick && block_in
    |=> !stage_out.start && !stage_out.trip)
    else $error("start kept while blocked");
  start_cause_a: assert property ($rose(stage_out.start)
    |-> $past(cycle_tick && !block_in))
    else $error("start without unblocked tick");
  blocked_cause_a: assert property ($rose(stage_out.blocked)
    |-> $past(cycle_tick && block_in))
    else $error("blocked without blocking");
  trip_order_a: assert property ($rose(stage_out.trip) |-> $past(stage_out.start))
    else $error("trip without start");
  sf_fix_a: assert property (setting_fault_flag.sf_fault
    |-> service_factor_used == thermal_stage_pkg::FACTOR_ONE)
    else $error("service factor not forced");
  nom_fix_a: assert property (setting_fault_flag.nominal_fault
    |-> nominal_used == thermal_stage_pkg::FACTOR_ONE)
    else $error("nominal factor not forced");
  load_high_a: assert property (cycle_tick && current_meas > 16'h00C8
    |=> load_class == 2'h3)
    else $error("high overload not shown");
endmodule // thermal_stage_checker
bind thermal_stage thermal_stage_checker #(.PROG_CYCLE_CLKS(PROG_CYCLE_CLKS)) u_chk (
  .clock, .rst, .current_meas, .block_in, .stage_out, .operating_condition_code, .load_class,
  .setting_fault_flag, .ambient_k_used, .service_factor_used, .nominal_used, .cycle_tick);
`default_nettype wire

// file: testbench/block_source.sv
// blocking matrix model driving the stage's blocking input
`timescale 1ns/10ps
`default_nettype none
module block_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic cycle_tick,
  input wire logic want,
  output logic block_in
);
  // moves only after an evaluation edge, so it is steady a full cycle before use
  always_ff @(posedge clock or posedge rst)
    if (rst) block_in <= 1'b0;
    else if (cycle_tick) block_in <= want;
endmodule // block_source
`default_nettype wire

// file: testbench/tb_thermal_stage.sv
// self-checking testbench for the thermal overload output stage
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_thermal_stage;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, block_in, cycle_tick;
  logic [10:0] capacity = 11'h000;
  logic [15:0] current_meas = 16'h0064;
  logic signed [12:0] ambient_temp = 13'h0096;
  thermal_stage_pkg::stage_out_t so;
  thermal_stage_pkg::cond_t cond;
  thermal_stage_pkg::load_class_t load;
  thermal_stage_pkg::fault_flags_t flags;
  logic [8:0] k_amb, k_sf, k_nom;
  int failures = 0, n_compared = 0;
  // short program cycle keeps the run brief
  thermal_stage #(.PROG_CYCLE_CLKS(20)) u_dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capacity(capacity), .current_meas(current_meas),
    .ambient_temp(ambient_temp), .block_in(block_in), .stage_out(so),
    .operating_condition_code(cond), .load_class(load), .setting_fault_flag(flags),
    .ambient_k_used(k_amb), .service_factor_used(k_sf), .nominal_used(k_nom),
    .cycle_tick(cycle_tick));
  block_source u_blk (.clock(clock), .rst(rst), .cycle_tick(cycle_tick), .want(want),
    .block_in(block_in));
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    close_out();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 16) timeout();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    int i;
    repeat (n)
    begin
      for (i = 0; i < 64; i++)
      begin
        @(negedge clock);
        if (cycle_tick === 1'b1) break;
      end
      if (i == 64) timeout();
      @(negedge clock);
    end
  endtask
  // inputs change one clock after a tick so the next tick surely sees them
  task automatic step(input logic [10:0] c, input logic [15:0] m);
    tick(1);
    @(posedge clock);
    capacity <= c;
    current_meas <= m;
    tick(1);
  endtask
  task automatic kchk(input logic [12:0] t, input logic [8:0] e);
    @(posedge clock);
    ambient_temp <= t;
    repeat (3) @(negedge clock);
    `CHK("ambient k", e, k_amb)
  endtask
  task automatic fchk(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(negedge clock);
  endtask
  task automatic lchk(input logic [15:0] m, input logic [1:0] e);
    step(11'h000, m);
    `CHK("load class", e, load)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] ev [6] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3E8, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset value", ev[i], q)
    end
    apb(1'b0, 8'h34, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    step(11'h4B0, 16'h0064);
    `CHK("disabled outputs", 6'h00, so)
    `CHK("disabled cond", 3'h0, cond)
    $display("test registers done");
  endtask
  task automatic t_stage();
    apb(1'b1, 8'h00, 32'h0000000F);
    apb(1'b1, 8'h04, 32'h000001F4);
    apb(1'b1, 8'h14, 32'h00000002);
    step(11'h1F4, 16'h0064);
    `CHK("alarm1 at level", 1'b1, so.alarm1)
    step(11'h1F3, 16'h0064);
    `CHK("alarm1 below", 1'b0, so.alarm1)
    `CHK("alarm2 cond", 3'h2, cond)
    step(11'h3E8, 16'h0064);
    `CHK("start", 1'b1, so.start)
    `CHK("early trip", 1'b0, so.trip)
    tick(2);
    `CHK("delayed trip", 1'b0, so.trip)
    tick(1);
    `CHK("trip", 1'b1, so.trip)
    `CHK("trip cond", 3'h4, cond)
    @(posedge clock);
    want <= 1'b1;
    tick(2);
    `CHK("start cleared", 1'b0, so.start)
    tick(1);
    `CHK("blocked", 1'b1, so.blocked)
    `CHK("blocked cond", 3'h5, cond)
    // status word: load normal, condition blocked, only the blocked output on
    apb(1'b0, 8'h2C, 32'h0);
    `CHK("status word", 32'h0000_0341, q)
    @(posedge clock);
    want <= 1'b0;
    step(11'h000, 16'h0064);
    `CHK("released", 6'h00, so)
    $display("test stage done");
  endtask
  task automatic t_faults();
    fchk(8'h18, 32'h0);
    `CHK("sf fault", 1'b1, flags.sf_fault)
    `CHK("sf forced", 9'h064, k_sf)
    fchk(8'h18, 32'h96);
    `CHK("sf fault gone", 1'b0, flags.sf_fault)
    `CHK("sf live", 9'h096, k_sf)
    fchk(8'h1C, 32'h0);
    `CHK("nominal fault", 1'b1, flags.nominal_fault)
    `CHK("nominal forced", 9'h064, k_nom)
    fchk(8'h20, 32'h006401C2);
    `CHK("ambient fault", 1'b1, flags.ambient_fault)
    fchk(8'h20, 32'h00500000);
    fchk(8'h24, 32'h007801C2);
    kchk(13'h1FF6, 9'h050);
    kchk(13'h01F4, 9'h078);
    apb(1'b1, 8'h00, 32'h0000001F);
    apb(1'b1, 8'h40, 32'h00500064);
    apb(1'b1, 8'h44, 32'h0078012C);
    apb(1'b1, 8'h48, 32'h019000C8);
    kchk(13'h00FA, 9'h050);
    kchk(13'h1FCE, 9'h050);
    kchk(13'h01F4, 9'h078);
    fchk(8'h44, 32'h0000012C);
    `CHK("k fault", 1'b1, flags.ambient_k_fault)
    `CHK("k forced", 9'h064, k_amb)
    lchk(16'h0000, 2'h0);
    lchk(16'h012C, 2'h3);
    lchk(16'h0096, 2'h2);
    lchk(16'h0032, 2'h1);
    $display("test faults done");
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_stage();
    t_faults();
    close_out();
  end
endmodule // tb_thermal_stage
`default_nettype wire
